// ### pcg_pkg.sv
// constants for the event-counter global control block
// assumes one core clock; register access arrives as model-register read/write strobes
// What this block does
// R01 - three fixed counters, each tied to one fixed event input
// R02 - fixed counter control sits at 38DH, needs no unit mask
// R03 - one write to global enable gates any mix of counters
// R04 - one read of global status returns every counter overflow
// R05 - one write to overflow clear clears any chosen overflow bits
// R06 - debug control bits 11 and 12 freeze branch records or counters on interrupt
// R07 - capability word bits 0-4 give number of fixed counters
// R08 - capability bits 5-12 give fixed width; software writes zero above it
// R09 - fixed control holds one 4-bit field per fixed counter
// R10 - field bit 0 counts events at ring zero
// R11 - field bit 1 counts events above ring zero
// R12 - both bits clear stops counter; both set counts always
// R13 - field bit 3 raises overflow interrupt for that counter
// R14 - counter runs only when global enable AND local enables
// R15 - status bits 0,1 and 32-34 set on counter overflow
// R16 - status holds sampling-buffer overflow and condition-changed bits
// R17 - precise sampling overflow: interrupt, record, clear counter status, set buffer bit
// R18 - software should clear overflows when reprogramming or disabling
// R19 - code 2EH mask 41H counts last-level cache misses
// R20 - code C4H mask 00H counts retired branches
// R21 - code C5H counts retired mispredicted branches
// R22 - general event select bit 22 is the local enable
// R23 - overflow is carry out of counter width, sticky until cleared
package pcg_pkg;
    // ------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------
    localparam logic [31:0] ADDR_FIXED_CTRL = 32'h0000_038d;
    localparam logic [31:0] ADDR_GLOBAL_EN = 32'h0000_03f0;
    localparam logic [31:0] ADDR_GLOBAL_STATUS = 32'h0000_03f1;
    localparam logic [31:0] ADDR_GLOBAL_CLEAR = 32'h0000_03f2;
    localparam logic [31:0] ADDR_DEBUG = 32'h0000_03f3;
    localparam logic [31:0] ADDR_SAMPLE_EN = 32'h0000_03f4;
    localparam logic [31:0] ADDR_FIXED_CTR0 = 32'h0000_03f8;
    localparam logic [31:0] ADDR_GP_CTR0 = 32'h0000_03e0;
    localparam logic [31:0] ADDR_GP_SEL0 = 32'h0000_03e8;
    // ------------------------------------------------------------
    // field layouts
    // ------------------------------------------------------------
    localparam int FIELD_W = 4;
    localparam int FLD_RING0 = 0;
    localparam int FLD_RINGN = 1;
    localparam int FLD_IRQ = 3;
    localparam int FIXED_BASE = 32;
    localparam int BIT_BUF_OVF = 62;
    localparam int BIT_COND_CHG = 63;
    localparam int SEL_USR = 16;
    localparam int SEL_OS = 17;
    localparam int SEL_IRQ = 20;
    localparam int SEL_EN = 22;
    localparam int DBG_FRZ_BR = 11;
    localparam int DBG_FRZ_CTR = 12;
    localparam int CAP_NUM_LSB = 0;
    localparam int CAP_WID_LSB = 5;
    // ------------------------------------------------------------
    // event encodings
    // ------------------------------------------------------------
    localparam logic [7:0] EV_LLC_MISS = 8'h2e;
    localparam logic [7:0] UM_LLC_MISS = 8'h41;
    localparam logic [7:0] EV_BR_RET = 8'hc4;
    localparam logic [7:0] UM_BR_RET = 8'h00;
    localparam logic [7:0] EV_BR_MISP = 8'hc5;
endpackage

// ### pcg_perf_ctl.sv
// fixed and general event counters with global enable, status and clear
// assumes event and privilege inputs come from logic on the same core clock
module pcg_perf_ctl #(
    parameter int NF = 3,
    parameter int NG = 2,
    parameter int FW = 48,
    parameter int GW = 48
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [31:0] regAddr,
    input wire logic regWrEn,
    input wire logic [63:0] regWrData,
    input wire logic regRdEn,
    output logic [63:0] regRdData,
    output logic regRdValid,
    output logic regFault,
    input wire logic ringZero,
    input wire logic [NF-1:0] fixedEvt,
    input wire logic evtLlcMiss,
    input wire logic evtBranchRetired,
    input wire logic evtBranchMispredict,
    output logic ovfIrq,
    output logic [NG-1:0] sampleRecordWr,
    output logic branchFreezeReq,
    output logic [31:0] capEdx
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    localparam logic [63:0] CNT_MASK = 64'((64'(1) << NG) - 64'(1))
        | (64'((64'(1) << NF) - 64'(1)) << pcg_pkg::FIXED_BASE);
    localparam logic [63:0] STAT_MASK = CNT_MASK | (64'(1) << pcg_pkg::BIT_BUF_OVF)
        | (64'(1) << pcg_pkg::BIT_COND_CHG);

    typedef struct packed {
        logic [NF*pcg_pkg::FIELD_W-1:0] fixCtl;
        logic [63:0] globEn;
        logic [63:0] status;
        logic frzBr;
        logic frzCtr;
        logic [NG-1:0] sampleEn;
        logic [NF-1:0][FW-1:0] fixCnt;
        logic [NG-1:0][GW-1:0] gpCnt;
        logic [NG-1:0][31:0] gpSel;
        logic [63:0] rdData;
        logic rdValid;
        logic fault;
        logic irq;
        logic [NG-1:0] sampleWr;
        logic brFreeze;
    } pcg_state_t;

    pcg_state_t s_q;
    pcg_state_t s_d;
    logic [NF-1:0] fixInc;
    logic [NG-1:0] gpInc;
    logic [63:0] ovfSet;
    logic bufOvf;
    logic condChg;

    // capability word: count and width of fixed counters
    assign capEdx = (32'(NF) << pcg_pkg::CAP_NUM_LSB) | (32'(FW) << pcg_pkg::CAP_WID_LSB); // R07 R08
    assign regRdData = s_q.rdData;
    assign regRdValid = s_q.rdValid;
    assign regFault = s_q.fault;
    assign ovfIrq = s_q.irq;
    assign sampleRecordWr = s_q.sampleWr;
    assign branchFreezeReq = s_q.brFreeze;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [pcg_pkg::FIELD_W-1:0] ctl;
        logic [31:0] sel;
        logic match;
        logic [FW:0] fsum;
        logic [GW:0] gsum;
        logic hit;
        logic [63:0] ovfDrop;
        s_d = s_q;
        ctl = '0;
        sel = '0;
        match = 1'b0;
        fsum = '0;
        gsum = '0;
        hit = 1'b0;
        ovfDrop = '0;
        fixInc = '0;
        gpInc = '0;
        ovfSet = '0;
        bufOvf = 1'b0;
        condChg = 1'b0;
        s_d.rdValid = 1'b0;
        s_d.fault = 1'b0;
        s_d.irq = 1'b0;
        s_d.sampleWr = '0;
        s_d.brFreeze = 1'b0;

        for (int i = 0; i < NF; i++) begin
            ctl = s_q.fixCtl[i*pcg_pkg::FIELD_W +: pcg_pkg::FIELD_W]; // R09
            fixInc[i] = fixedEvt[i] & s_q.globEn[pcg_pkg::FIXED_BASE+i] // R01 R14
                & ((ctl[pcg_pkg::FLD_RING0] & ringZero) // R10 R12
                | (ctl[pcg_pkg::FLD_RINGN] & ~ringZero)); // R11
            fsum = {1'b0, s_q.fixCnt[i]} + (FW+1)'(1);
            if (fixInc[i]) begin
                s_d.fixCnt[i] = fsum[FW-1:0];
                if (fsum[FW]) begin
                    ovfSet[pcg_pkg::FIXED_BASE+i] = 1'b1; // R23 R15
                    if (ctl[pcg_pkg::FLD_IRQ]) begin
                        s_d.irq = 1'b1; // R13
                    end
                end
            end
        end

        for (int j = 0; j < NG; j++) begin
            sel = s_q.gpSel[j];
            match = ((sel[7:0] == pcg_pkg::EV_LLC_MISS) && (sel[15:8] == pcg_pkg::UM_LLC_MISS)
                && evtLlcMiss) // R19
                || ((sel[7:0] == pcg_pkg::EV_BR_RET) && (sel[15:8] == pcg_pkg::UM_BR_RET)
                && evtBranchRetired) // R20
                || ((sel[7:0] == pcg_pkg::EV_BR_MISP) && evtBranchMispredict); // R21
            gpInc[j] = match & sel[pcg_pkg::SEL_EN] & s_q.globEn[j] // R22 R14
                & ((sel[pcg_pkg::SEL_OS] & ringZero) | (sel[pcg_pkg::SEL_USR] & ~ringZero));
            gsum = {1'b0, s_q.gpCnt[j]} + (GW+1)'(1);
            if (gpInc[j]) begin
                s_d.gpCnt[j] = gsum[GW-1:0];
                if (gsum[GW]) begin
                    if (s_q.sampleEn[j]) begin
                        // precise sampling: record, and drop any stale flag of this counter
                        s_d.irq = 1'b1; // R17
                        s_d.sampleWr[j] = 1'b1;
                        bufOvf = 1'b1;
                        ovfDrop[j] = 1'b1;
                    end else begin
                        ovfSet[j] = 1'b1; // R23 R15
                        if (sel[pcg_pkg::SEL_IRQ]) begin
                            s_d.irq = 1'b1;
                        end
                    end
                end
            end
        end

        // ------------------------------------------------------------
        // register writes; a counter write beats its own increment
        // ------------------------------------------------------------
        if (regWrEn) begin
            hit = 1'b1;
            unique case (regAddr)
                pcg_pkg::ADDR_FIXED_CTRL: begin
                    s_d.fixCtl = regWrData[NF*pcg_pkg::FIELD_W-1:0]; // R02
                end
                pcg_pkg::ADDR_GLOBAL_EN: begin
                    s_d.globEn = regWrData & CNT_MASK; // R03
                    condChg = (regWrData & CNT_MASK) != s_q.globEn; // R16
                end
                pcg_pkg::ADDR_GLOBAL_CLEAR: begin
                    s_d.status = s_q.status & ~(regWrData & STAT_MASK); // R05
                end
                pcg_pkg::ADDR_DEBUG: begin
                    s_d.frzBr = regWrData[pcg_pkg::DBG_FRZ_BR]; // R06
                    s_d.frzCtr = regWrData[pcg_pkg::DBG_FRZ_CTR];
                end
                pcg_pkg::ADDR_SAMPLE_EN: begin
                    s_d.sampleEn = regWrData[NG-1:0];
                end
                default: begin
                    hit = 1'b0;
                end
            endcase
            for (int i = 0; i < NF; i++) begin
                if (regAddr == pcg_pkg::ADDR_FIXED_CTR0 + 32'(i)) begin
                    s_d.fixCnt[i] = regWrData[FW-1:0]; // R08
                    hit = 1'b1;
                end
            end
            for (int j = 0; j < NG; j++) begin
                if (regAddr == pcg_pkg::ADDR_GP_CTR0 + 32'(j)) begin
                    s_d.gpCnt[j] = regWrData[GW-1:0];
                    hit = 1'b1;
                end
                if (regAddr == pcg_pkg::ADDR_GP_SEL0 + 32'(j)) begin
                    s_d.gpSel[j] = regWrData[31:0];
                    hit = 1'b1;
                end
            end
            s_d.fault = ~hit;
        end

        // set wins over a clear in the same cycle
        s_d.status = (s_d.status & ~ovfDrop) | ovfSet // R15 R23
            | (64'(bufOvf) << pcg_pkg::BIT_BUF_OVF) // R16 R17
            | (64'(condChg) << pcg_pkg::BIT_COND_CHG);

        // legacy freeze: interrupt drops every global enable
        if (s_d.irq && s_q.frzCtr) begin
            s_d.globEn = '0; // R06
        end
        s_d.brFreeze = s_d.irq & s_q.frzBr; // R06

        // ------------------------------------------------------------
        // register reads, answered one cycle later
        // ------------------------------------------------------------
        if (regRdEn) begin
            s_d.rdValid = 1'b1;
            s_d.rdData = '0;
            hit = 1'b1;
            unique case (regAddr)
                pcg_pkg::ADDR_FIXED_CTRL: s_d.rdData = 64'(s_q.fixCtl);
                pcg_pkg::ADDR_GLOBAL_EN: s_d.rdData = s_q.globEn;
                pcg_pkg::ADDR_GLOBAL_STATUS: s_d.rdData = s_q.status; // R04
                pcg_pkg::ADDR_GLOBAL_CLEAR: s_d.rdData = '0;
                pcg_pkg::ADDR_DEBUG: s_d.rdData = (64'(s_q.frzBr) << pcg_pkg::DBG_FRZ_BR)
                    | (64'(s_q.frzCtr) << pcg_pkg::DBG_FRZ_CTR);
                pcg_pkg::ADDR_SAMPLE_EN: s_d.rdData = 64'(s_q.sampleEn);
                default: hit = 1'b0;
            endcase
            for (int i = 0; i < NF; i++) begin
                if (regAddr == pcg_pkg::ADDR_FIXED_CTR0 + 32'(i)) begin
                    s_d.rdData = 64'(s_q.fixCnt[i]);
                    hit = 1'b1;
                end
            end
            for (int j = 0; j < NG; j++) begin
                if (regAddr == pcg_pkg::ADDR_GP_CTR0 + 32'(j)) begin
                    s_d.rdData = 64'(s_q.gpCnt[j]);
                    hit = 1'b1;
                end
                if (regAddr == pcg_pkg::ADDR_GP_SEL0 + 32'(j)) begin
                    s_d.rdData = 64'(s_q.gpSel[j]);
                    hit = 1'b1;
                end
            end
            s_d.fault = s_d.fault | ~hit;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence fixWrap0;
        fixInc[0] && (s_q.fixCnt[0] == {FW{1'b1}});
    endsequence
    sequence noFixWrite0;
        !(regWrEn && regAddr == pcg_pkg::ADDR_FIXED_CTR0);
    endsequence
    sequence clearFix0;
        regWrEn && regAddr == pcg_pkg::ADDR_GLOBAL_CLEAR && regWrData[pcg_pkg::FIXED_BASE];
    endsequence

    a_fix_ovf_status: assert property (fixWrap0 and noFixWrite0 |=> // R15
        s_q.status[pcg_pkg::FIXED_BASE] && s_q.fixCnt[0] == '0)
        else $error("fixed overflow did not set status");
    a_fix_ovf_irq: assert property (fixWrap0 ##0 s_q.fixCtl[pcg_pkg::FLD_IRQ] |=> ovfIrq) // R13
        else $error("fixed overflow interrupt missing");
    a_count_gate: assert property (fixInc[0] |-> s_q.globEn[pcg_pkg::FIXED_BASE] // R14
        && s_q.fixCtl[pcg_pkg::FLD_RINGN:pcg_pkg::FLD_RING0] != 2'b00)
        else $error("fixed counter ran while gated off");
    a_count_hold: assert property (!fixInc[0] and noFixWrite0 |=> $stable(s_q.fixCnt[0])) // R12
        else $error("fixed counter moved without event");
    a_ovf_sticky: assert property (s_q.status[pcg_pkg::FIXED_BASE] && !regWrEn |=> // R23
        s_q.status[pcg_pkg::FIXED_BASE])
        else $error("overflow status dropped without clear");
    a_ovf_clear: assert property (clearFix0 and !fixWrap0 |=> // R05
        !s_q.status[pcg_pkg::FIXED_BASE])
        else $error("overflow clear ignored");
    a_read_answer: assert property (regRdEn |=> regRdValid ##1 !regRdValid || $past(regRdEn)) // R04
        else $error("read answer not one cycle");
    a_sample_ovf: assert property (gpInc[0] && s_q.gpCnt[0] == {GW{1'b1}} && s_q.sampleEn[0] // R17
        && !regWrEn |=> sampleRecordWr[0] && ovfIrq && s_q.status[pcg_pkg::BIT_BUF_OVF]
        && !s_q.status[0])
        else $error("precise sampling overflow mishandled");
    a_cond_chg: assert property (regWrEn && regAddr == pcg_pkg::ADDR_GLOBAL_EN // R16
        && (regWrData & CNT_MASK) != s_q.globEn |=> s_q.status[pcg_pkg::BIT_COND_CHG])
        else $error("condition-changed bit not set");
    a_ctr_freeze: assert property (s_d.irq && s_q.frzCtr |=> s_q.globEn == '0 && ovfIrq) // R06
        else $error("counter freeze on interrupt failed");
endmodule

// ### pcg_evt_src.sv
// event source model: fixed, cache-miss and branch retirement pulses
// assumes the bench requests a burst at the falling edge of clk
module pcg_evt_src (
    input wire logic clk,
    input wire logic go,
    input wire logic [5:0] sel,
    input wire logic ring,
    input wire logic [7:0] len,
    output logic ringZero,
    output logic [2:0] fixedEvt,
    output logic evtLlcMiss,
    output logic evtBranchRetired,
    output logic evtBranchMispredict
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // burst of len back-to-back occurrences
    // ----------------------------------------
    logic [7:0] left_q = 8'h00;
    logic [5:0] act;
    always @(negedge clk) begin
        if (go) begin
            left_q <= len;
        end else if (left_q != 8'h00) begin
            left_q <= left_q - 8'h01;
        end
    end
    // sources are plain logic, so an idle event line is a clean 0
    assign act = (left_q != 8'h00) ? sel : 6'h00;
    assign {evtBranchMispredict, evtBranchRetired, evtLlcMiss, fixedEvt} = act;
    assign ringZero = ring;
endmodule

// ### test_perf_counter_global_control.sv
// self-checking bench for the event-counter global control block
// assumes pcg_pkg, pcg_perf_ctl and pcg_evt_src are compiled first
module test_perf_counter_global_control;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [63:0] d; logic f;} pcg_note_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [31:0] regAddr = 32'h0;
    logic regWrEn = 1'b0;
    logic [63:0] regWrData = 64'h0;
    logic regRdEn = 1'b0;
    logic [63:0] regRdData;
    logic regRdValid, regFault, ringZero, ovfIrq, branchFreezeReq;
    logic evtLlcMiss, evtBranchRetired, evtBranchMispredict;
    logic [2:0] fixedEvt;
    logic [1:0] sampleRecordWr;
    logic [31:0] capEdx;
    logic evGo = 1'b0;
    logic [5:0] evSel = 6'h00;
    logic evRing = 1'b0;
    logic [7:0] evLen = 8'h00;
    int error_cnt = 0;
    int samples_checked = 0;
    int irqCnt = 0, recCnt = 0, frzCnt = 0, cyc = 0;
    pcg_note_t notes[$];
    pcg_note_t nt;

    always #50 clk = ~clk;

    pcg_perf_ctl dut_u (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrEn(regWrEn),
        .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
        .regRdValid(regRdValid), .regFault(regFault), .ringZero(ringZero),
        .fixedEvt(fixedEvt), .evtLlcMiss(evtLlcMiss), .evtBranchRetired(evtBranchRetired),
        .evtBranchMispredict(evtBranchMispredict), .ovfIrq(ovfIrq),
        .sampleRecordWr(sampleRecordWr), .branchFreezeReq(branchFreezeReq), .capEdx(capEdx));
    pcg_evt_src src_u (.clk(clk), .go(evGo), .sel(evSel), .ring(evRing), .len(evLen),
        .ringZero(ringZero), .fixedEvt(fixedEvt), .evtLlcMiss(evtLlcMiss),
        .evtBranchRetired(evtBranchRetired), .evtBranchMispredict(evtBranchMispredict));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic conclude();
        $display("checked %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [63:0] d);
        @(negedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(negedge clk);
        regWrEn <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, input logic [63:0] d, input logic f);
        @(negedge clk);
        notes.push_back('{d, f});
        regAddr <= a;
        regRdEn <= 1'b1;
        @(negedge clk);
        regRdEn <= 1'b0;
        @(negedge clk);
    endtask
    // burst length is set by n, so waiting n+2 cycles covers the whole burst
    task automatic fire(input logic [5:0] s, input logic r, input logic [7:0] n);
        @(negedge clk);
        evSel <= s;
        evRing <= r;
        evLen <= n;
        evGo <= 1'b1;
        @(negedge clk);
        evGo <= 1'b0;
        repeat (int'(n) + 2) @(negedge clk);
    endtask

    // ----------------------------------------
    // answer monitor and hang guard
    // ----------------------------------------
    always @(posedge clk) begin
        cyc++;
        if (regRdValid === 1'b1 || regFault === 1'b1) begin
            if (notes.size() == 0) begin
                chk(64'h1, 64'h0);
            end else begin
                nt = notes.pop_front();
                chk(regRdData, nt.d);
                chk({63'h0, regFault}, {63'h0, nt.f});
            end
        end
        irqCnt += (ovfIrq === 1'b1) ? 1 : 0;
        recCnt += (sampleRecordWr[0] === 1'b1) ? 1 : 0;
        frzCnt += (branchFreezeReq === 1'b1) ? 1 : 0;
        if (cyc == 3000) begin
            error_cnt++;
            conclude();
        end
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        int b0, b1, n;
        logic [15:0] codes [4] = '{16'h412e, 16'h4f2e, 16'h00c4, 16'h00c5};
        void'($urandom(89795));
        repeat (4) @(posedge clk);
        @(negedge clk);
        rst <= 1'b0;
        chk({51'h0, capEdx[12:0]}, 64'h603);
        rd(pcg_pkg::ADDR_FIXED_CTRL, 64'h0, 1'b0);
        rd(pcg_pkg::ADDR_GLOBAL_STATUS, 64'h0, 1'b0);
        rd(32'h0000_0100, 64'h0, 1'b1);
        wr(pcg_pkg::ADDR_GLOBAL_EN, 64'h7_0000_0003);
        for (int f = 0; f < 4; f++) begin
            wr(pcg_pkg::ADDR_FIXED_CTRL, 64'h303 | (64'(f) << 4));
            wr(pcg_pkg::ADDR_FIXED_CTR0 + 32'h1, 64'h0);
            fire(6'h02, 1'b1, 8'h03);
            fire(6'h02, 1'b0, 8'h02);
            rd(pcg_pkg::ADDR_FIXED_CTR0 + 32'h1, 64'(f[0] * 3 + f[1] * 2), 1'b0);
        end
        rd(pcg_pkg::ADDR_FIXED_CTRL, 64'h333, 1'b0);
        wr(pcg_pkg::ADDR_GLOBAL_EN, 64'h5_0000_0003);
        wr(pcg_pkg::ADDR_FIXED_CTR0 + 32'h1, 64'h0);
        fire(6'h03, 1'b1, 8'h04);
        rd(pcg_pkg::ADDR_FIXED_CTR0, 64'h4, 1'b0);
        rd(pcg_pkg::ADDR_FIXED_CTR0 + 32'h1, 64'h0, 1'b0);
        wr(pcg_pkg::ADDR_GLOBAL_CLEAR, '1);
        rd(pcg_pkg::ADDR_GLOBAL_STATUS, 64'h0, 1'b0);
        wr(pcg_pkg::ADDR_FIXED_CTRL, 64'h999);
        wr(pcg_pkg::ADDR_FIXED_CTR0, 64'hffff_ffff_ffff);
        wr(pcg_pkg::ADDR_FIXED_CTR0 + 32'h2, 64'hffff_ffff_ffff);
        b0 = irqCnt;
        fire(6'h05, 1'b1, 8'h01);
        chk(64'(irqCnt - b0), 64'h1);
        rd(pcg_pkg::ADDR_GLOBAL_STATUS, 64'h5_0000_0000, 1'b0);
        rd(pcg_pkg::ADDR_FIXED_CTR0, 64'h0, 1'b0);
        wr(pcg_pkg::ADDR_GLOBAL_CLEAR, 64'h1_0000_0000);
        rd(pcg_pkg::ADDR_GLOBAL_STATUS, 64'h4_0000_0000, 1'b0);
        wr(pcg_pkg::ADDR_GLOBAL_EN, 64'h7_0000_0003);
        rd(pcg_pkg::ADDR_GLOBAL_STATUS, 64'h8000_0004_0000_0000, 1'b0);
        wr(pcg_pkg::ADDR_GLOBAL_CLEAR, '1);
        // all three sources fire; only the matching code may count
        for (int k = 0; k < 4; k++) begin
            n = $urandom_range(6, 1);
            wr(pcg_pkg::ADDR_GP_CTR0 + 32'(k % 2), 64'h0);
            wr(pcg_pkg::ADDR_GP_SEL0 + 32'(k % 2), {48'h0, codes[k]} | 64'h43_0000);
            fire(6'h38, 1'b1, 8'(n));
            rd(pcg_pkg::ADDR_GP_CTR0 + 32'(k % 2), (k == 1) ? 64'h0 : 64'(n), 1'b0);
        end
        // plain overflow first, so the sampling overflow has a flag to drop
        wr(pcg_pkg::ADDR_GP_SEL0, 64'h53_00c4);
        wr(pcg_pkg::ADDR_GP_CTR0, 64'hffff_ffff_ffff);
        b0 = irqCnt;
        fire(6'h10, 1'b1, 8'h01);
        chk(64'(irqCnt - b0), 64'h1);
        rd(pcg_pkg::ADDR_GLOBAL_STATUS, 64'h1, 1'b0);
        wr(pcg_pkg::ADDR_SAMPLE_EN, 64'h1);
        wr(pcg_pkg::ADDR_GP_CTR0, 64'hffff_ffff_ffff);
        b0 = irqCnt;
        b1 = recCnt;
        fire(6'h10, 1'b1, 8'h01);
        chk(64'(irqCnt - b0), 64'h1);
        chk(64'(recCnt - b1), 64'h1);
        rd(pcg_pkg::ADDR_GLOBAL_STATUS, 64'h4000_0000_0000_0000, 1'b0);
        wr(pcg_pkg::ADDR_DEBUG, 64'h1800);
        rd(pcg_pkg::ADDR_DEBUG, 64'h1800, 1'b0);
        wr(pcg_pkg::ADDR_GP_CTR0, 64'hffff_ffff_ffff);
        b0 = frzCnt;
        fire(6'h10, 1'b1, 8'h01);
        chk(64'(frzCnt - b0), 64'h1);
        rd(pcg_pkg::ADDR_GLOBAL_EN, 64'h0, 1'b0);
        repeat (4) @(negedge clk);
        conclude();
    end
endmodule
